// File: hdl/fnpa_pkg.sv
// Shared constants and types of the fractional-N phase accumulator
package fnpa_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 32'h0131_2d00; // 20 MHz system clock
  localparam int unsigned REF_HZ = 32'h0001_86a0; // 100 kHz loop reference
  // Cycles per reference period, derived from the two rates
  localparam int unsigned REF_PERIOD_CYC = CLK_HZ / REF_HZ;

  // ==========================================================
  // Sequencer program
  localparam int unsigned STEP_COUNT = 32'h0000_0011; // Seventeen steps
  localparam logic [4:0] ADDR_RST = 5'h00;            // First program step
  localparam logic [4:0] LAST_STEP = 5'h10;           // Index of the halt

  // ==========================================================
  // Datapath constants
  localparam logic [3:0] PW_TERMINAL = 4'hf; // Width counter end count
  localparam logic [4:0] BCD_BASE = 5'h0a;   // Decimal radix
  localparam logic [3:0] DIGIT_RST = 4'h0;   // Accumulator digit at reset
  localparam logic [2:0] PULSE_IDLE = 3'h7;  // All correction pulses high

  // ==========================================================
  // Register map (byte offsets) and fields
  localparam int unsigned AV_ADDR_W = 32'h0000_0004;
  localparam logic [3:0] REG_CTRL = 4'h0;   // Control
  localparam logic [3:0] REG_FRAC = 4'h4;   // Fractional digits
  localparam logic [3:0] REG_STATUS = 4'h8; // Status and accumulator
  localparam int unsigned CTRL_EN_BIT = 32'h0;
  localparam int unsigned ST_RUN_BIT = 32'h0;
  localparam int unsigned ST_NDC_BIT = 32'h1;
  localparam int unsigned ST_OVR_BIT = 32'h2;
  localparam int unsigned ST_BUSY_BIT = 32'h3;
  localparam int unsigned ST_ACC_LSB = 32'h4;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [11:0] FRAC_RST = 12'h000;

  // ==========================================================
  // Control words
  typedef enum logic [2:0] {
    OP_ADD,   // Add selected digit, capture, shift
    OP_CARRY, // Publish decimal carry as divide select
    OP_LOAD,  // Load width counter, start a pulse
    OP_WAIT,  // Hold until the pulse ends
    OP_ROT,   // Rotate chain to bring next digit low
    OP_NOP,   // Idle step
    OP_HALT   // Stop until the next period
  } fnpa_op_t;

  typedef struct packed {
    fnpa_op_t op;    // Operation
    logic [1:0] idx; // Digit or pulse index
  } fnpa_word_t;

endpackage

// File: hdl/fnpa_ctl_if.sv
// Control-word carrier between sequencer, datapath and pulse former
`timescale 1ns/1ps
interface fnpa_ctl_if;
  import fnpa_pkg::*;

  logic valid;      // Sequencer is issuing a step
  fnpa_word_t word; // Current control word
  logic busy;       // A correction pulse is in progress

  modport seq (output valid, output word, input busy);
  modport dp (input valid, input word, input busy);
  modport pg (input valid, input word, output busy);
endinterface

// File: hdl/fnpa_sequencer.sv
// Address generator and program table of the control sequencer
`timescale 1ns/1ps
module fnpa_sequencer (
  input wire logic clk,  // System clock
  input wire logic srst, // Synchronous reset
  input wire logic ce,   // Clock enable
  input wire logic start, // Period-end restart pulse
  fnpa_ctl_if.seq ctl    // Control words out
);
  import fnpa_pkg::*;

  // ==========================================================
  // Program table
  // Pulse for channel 2 first; rotations bring each digit low in turn
  localparam fnpa_word_t PROG [STEP_COUNT] = '{
    '{OP_ADD, 2'h0}, '{OP_ADD, 2'h1}, '{OP_ADD, 2'h2},
    '{OP_CARRY, 2'h0},
    '{OP_LOAD, 2'h2}, '{OP_WAIT, 2'h0}, '{OP_ROT, 2'h0},
    '{OP_LOAD, 2'h1}, '{OP_WAIT, 2'h0}, '{OP_ROT, 2'h0},
    '{OP_LOAD, 2'h0}, '{OP_WAIT, 2'h0}, '{OP_ROT, 2'h0},
    '{OP_NOP, 2'h0}, '{OP_NOP, 2'h0}, '{OP_NOP, 2'h0},
    '{OP_HALT, 2'h0}
  };

  logic [4:0] addr; // Step address
  logic running;    // Address generator enabled

  // ==========================================================
  // Address generator
  always_ff @(posedge clk) begin
    if (srst) begin
      addr <= ADDR_RST;
      running <= 1'b0;
    end else if (ce) begin
      if (start) begin
        addr <= ADDR_RST;
        running <= 1'b1;
      end else if (running) begin
        if (PROG[addr].op == OP_HALT) begin
          addr <= ADDR_RST;
          running <= 1'b0;
        end else if (!(PROG[addr].op == OP_WAIT && ctl.busy)) begin
          addr <= addr + 5'h01;
        end
      end
    end
  end

  // Words come straight from the table while enabled
  assign ctl.valid = running;
  assign ctl.word = PROG[addr];

endmodule // fnpa_sequencer

// File: hdl/fnpa_pulse_gen.sv
// Digital-to-pulse converter with its width counter
`timescale 1ns/1ps
module fnpa_pulse_gen (
  input wire logic clk,        // System clock
  input wire logic srst,       // Synchronous reset
  input wire logic ce,         // Clock enable
  input wire logic abort,      // Period restart ends any pulse
  input wire logic psc_edge,   // Prescaled clock rising edge
  input wire logic [3:0] digit, // Lowest accumulator digit
  fnpa_ctl_if.pg ctl,          // Control words in
  output logic [2:0] pulse_n   // Correction pulses, low active
);
  import fnpa_pkg::*;

  logic [3:0] cnt; // Width counter
  logic busy;      // Pulse running

  // ==========================================================
  // Width counter: runs from the complement up to the end count
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= DIGIT_RST;
      busy <= 1'b0;
      pulse_n <= PULSE_IDLE;
    end else if (ce) begin
      if (abort) begin
        // A stalled prescaler must not hang the next period
        busy <= 1'b0;
        pulse_n <= PULSE_IDLE;
      end else if (ctl.valid && ctl.word.op == OP_LOAD) begin
        cnt <= ~digit;
        busy <= 1'b1;
        pulse_n <= ~(3'h1 << ctl.word.idx);
      end else if (busy && psc_edge) begin
        if (cnt == PW_TERMINAL) begin
          cnt <= DIGIT_RST;
          busy <= 1'b0;
          pulse_n <= PULSE_IDLE;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  assign ctl.busy = busy;

endmodule // fnpa_pulse_gen

// File: hdl/fnpa_accumulator.sv
// Top of the BCD phase accumulator with its Avalon register slave
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// Operation
// - Per period, compute phase and drive outputs
// - Control words come from program table
// - Seventeen steps per period, last halts
// - Halt resets and disables address generator
// - Period-end pulse restarts the sequence
// - Accumulator grows by fraction each period
// - Unity reached asserts divide-minus-one select
// - Lowest digit selected first each period
// - Digit plus lowest register into top
// - Capture shifts top to mid, mid to low
// - Repeat for digits one and two
// - Pulses emitted in order three, two, one
// - Counter end at fifteen ends pulse
// - Counter loaded with complemented low digit
// - Counter clocked by prescaled oscillator clock
// - Width is ten times digit plus one
module fnpa_accumulator #(
  parameter int unsigned SYNC_STAGES = 2 // Pin synchroniser depth
) (
  input wire logic clk,  // 20 MHz clock
  input wire logic srst, // Synchronous reset, high
  input wire logic ce,   // Clock enable, freezes all state but the period reset of steps_seen and loads_seen
  input wire logic [fnpa_pkg::AV_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read,  // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest,     // Slave stall
  input wire logic acc_clock_pin,       // Period-end pulse, async
  input wire logic prescaled_vco_clock, // Prescaled VCO clock, async
  output logic divide_minus_one_select, // To the N-divider
  output logic [2:0] corr_pulse_n // Correction pulses, low active
);
  import fnpa_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ==========================================================
  // Declarations
  logic [SYNC_STAGES-1:0] acc_sync; // Period pin synchroniser
  logic [SYNC_STAGES-1:0] psc_sync; // Prescaled clock synchroniser
  logic acc_last; // Previous synchronised period level
  logic psc_last; // Previous synchronised prescaled level
  logic start;    // Period restart
  logic psc_edge; // Prescaled clock edge
  logic ctrl_en;  // Software enable
  logic [11:0] frac; // Fractional digits, low digit in low nibble
  logic ovr;      // Period ended before halt, sticky
  logic ack;      // Second cycle of a bus access
  logic req;      // Bus request present
  logic [3:0] accum_low_register; // Lowest accumulator digit
  logic [3:0] accum_mid_register; // Middle digit
  logic [3:0] accum_top_register; // Top digit
  logic carry;    // Decimal carry between digits
  logic [3:0] sel_digit;  // Multiplexer output
  logic [4:0] bcd_raw;    // Binary sum before correction
  logic [3:0] bcd_sum;    // Corrected digit
  logic bcd_cout;         // Decimal carry out
  logic [2:0] pulse_n;    // Pulse former output
  fnpa_ctl_if ctl ();     // Control word carrier

  wire [3:0] frac_digit_low = frac[3:0];
  wire [3:0] frac_digit_mid = frac[7:4];
  wire [3:0] frac_digit_high = frac[11:8];

  // ==========================================================
  // Pin synchronisers and edge detect
  // Both pins are asynchronous; only the last stage is looked at
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_sync <= '0;
      psc_sync <= '0;
      acc_last <= 1'b0;
      psc_last <= 1'b0;
    end else if (ce) begin
      acc_sync <= {acc_sync[SYNC_STAGES-2:0], acc_clock_pin};
      psc_sync <= {psc_sync[SYNC_STAGES-2:0], prescaled_vco_clock};
      acc_last <= acc_sync[SYNC_STAGES-1];
      psc_last <= psc_sync[SYNC_STAGES-1];
    end
  end

  // One restart per reference period, only while enabled
  assign start = acc_sync[SYNC_STAGES-1] & ~acc_last & ctrl_en;
  assign psc_edge = psc_sync[SYNC_STAGES-1] & ~psc_last;

  // ==========================================================
  // Sequencer and pulse former
  fnpa_sequencer u_seq (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start(start),
    .ctl(ctl.seq)
  );

  fnpa_pulse_gen u_pulse (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .abort(start),
    .psc_edge(psc_edge),
    .digit(accum_low_register),
    .ctl(ctl.pg),
    .pulse_n(pulse_n)
  );

  assign corr_pulse_n = pulse_n;

  // ==========================================================
  // Input multiplexer and BCD adder
  always_comb begin
    case (ctl.word.idx)
      2'h0: sel_digit = frac_digit_low;
      2'h1: sel_digit = frac_digit_mid;
      default: sel_digit = frac_digit_high;
    endcase
  end

  always_comb begin
    // Carry-in is dropped on the first digit of a period
    bcd_raw = {1'b0, sel_digit} + {1'b0, accum_low_register} +
              {4'h0, carry & (ctl.word.idx != 2'h0)};
    bcd_cout = (bcd_raw >= BCD_BASE);
    bcd_sum = bcd_cout ? 4'(bcd_raw - BCD_BASE) : bcd_raw[3:0];
  end

  // ==========================================================
  // Accumulator chain
  always_ff @(posedge clk) begin
    if (srst) begin
      accum_low_register <= DIGIT_RST;
      accum_mid_register <= DIGIT_RST;
      accum_top_register <= DIGIT_RST;
      carry <= 1'b0;
    end else if (ce && ctl.valid) begin
      if (ctl.word.op == OP_ADD) begin
        accum_top_register <= bcd_sum;
        accum_mid_register <= accum_top_register;
        accum_low_register <= accum_mid_register;
        carry <= bcd_cout;
      end else if (ctl.word.op == OP_ROT) begin
        // Three rotations restore the chain by period end
        accum_top_register <= accum_low_register;
        accum_mid_register <= accum_top_register;
        accum_low_register <= accum_mid_register;
      end else if (ctl.word.op == OP_CARRY) begin
        carry <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Divide select: held for the whole period
  always_ff @(posedge clk) begin
    if (srst) begin
      divide_minus_one_select <= 1'b0;
    end else if (ce && ctl.valid && ctl.word.op == OP_CARRY) begin
      divide_minus_one_select <= carry;
    end
  end

  // ==========================================================
  // Avalon slave: one wait state, then data or write
  assign req = avs_read | avs_write;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      ack <= req & ~ack;
      avs_waitrequest <= ~(req & ~ack);
    end
  end

  // Read data is built in the first cycle and stands in the second
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack) begin
      if (avs_address == REG_CTRL) begin
        avs_readdata <= {31'h0, ctrl_en};
      end else if (avs_address == REG_FRAC) begin
        avs_readdata <= {20'h0_0000, frac};
      end else if (avs_address == REG_STATUS) begin
        avs_readdata <= {16'h0000, accum_top_register, accum_mid_register,
                         accum_low_register, ctl.busy, ovr,
                         divide_minus_one_select, ctl.valid};
      end else begin
        avs_readdata <= 32'h0000_0000; // Unmapped reads zero
      end
    end
  end

  // Control and fraction registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_en <= CTRL_EN_RST;
      frac <= FRAC_RST;
    end else if (ce && avs_write && ack) begin
      if (avs_address == REG_CTRL) begin
        ctrl_en <= avs_writedata[CTRL_EN_BIT];
      end else if (avs_address == REG_FRAC) begin
        frac <= avs_writedata[11:0];
      end
    end
  end

  // Overrun: restart while still sequencing; set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      ovr <= 1'b0;
    end else if (ce) begin
      if (start && ctl.valid) begin
        ovr <= 1'b1;
      end else if (avs_write && ack && avs_address == REG_STATUS &&
                   avs_writedata[ST_OVR_BIT]) begin
        ovr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checking helpers
  logic [4:0] steps_seen; // Steps issued this period
  logic [1:0] loads_seen; // Pulses started this period
  logic [4:0] pw_edges;   // Prescaled edges during a pulse
  logic [3:0] pw_digit;   // Digit loaded for the pulse

  always_ff @(posedge clk) begin
    if (srst || start) begin
      steps_seen <= 5'h00;
      loads_seen <= 2'h0;
    end else if (ce && ctl.valid) begin
      if (!(ctl.word.op == OP_WAIT && ctl.busy) &&
          ctl.word.op != OP_HALT) begin
        steps_seen <= steps_seen + 5'h01;
      end
      if (ctl.word.op == OP_LOAD) begin
        loads_seen <= loads_seen + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pw_edges <= 5'h00;
      pw_digit <= DIGIT_RST;
    end else if (ce && ctl.valid && ctl.word.op == OP_LOAD) begin
      pw_edges <= 5'h00;
      pw_digit <= accum_low_register;
    end else if (ce && ctl.busy && psc_edge) begin
      pw_edges <= pw_edges + 5'h01;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  a_halt_stops_seq: assert property (
    ctl.valid && ctl.word.op == OP_HALT && !start |=> !ctl.valid)
    else $error("sequencer still running after halt");
  a_step_count: assert property (
    ctl.valid && ctl.word.op == OP_HALT |-> steps_seen == LAST_STEP)
    else $error("halt not at seventeenth step");
  a_restart_low: assert property (
    start |=> ctl.valid && ctl.word.op == OP_ADD && ctl.word.idx == 2'h0)
    else $error("period restart did not begin with low digit");
  a_add_capture: assert property (
    ctl.valid && ctl.word.op == OP_ADD && ctl.word.idx == 2'h0 |=>
    accum_top_register == 4'(({1'b0, $past(sel_digit)} +
      {1'b0, $past(accum_low_register)}) % BCD_BASE))
    else $error("top register does not hold digit sum");
  a_shift_chain: assert property (
    ctl.valid && ctl.word.op == OP_ADD |=>
    accum_mid_register == $past(accum_top_register) &&
    accum_low_register == $past(accum_mid_register))
    else $error("chain did not shift right");
  a_ndc_carry: assert property (
    ctl.valid && ctl.word.op == OP_CARRY |=>
    divide_minus_one_select == $past(carry))
    else $error("divide select does not follow carry");
  a_pulse_order: assert property (
    ctl.valid && ctl.word.op == OP_LOAD && !start |->
    ctl.word.idx == 2'h2 - loads_seen ##1 corr_pulse_n[$past(ctl.word.idx)]
    == 1'b0)
    else $error("correction pulses out of order");
  a_one_pulse: assert property (
    $onehot0(~corr_pulse_n))
    else $error("two correction pulses at once");
  a_pulse_width: assert property (
    $fell(ctl.busy) && !$past(start) |->
    pw_edges == {1'b0, pw_digit} + 5'h01)
    else $error("pulse width not digit plus one edges");
  a_digit_range: assert property (
    frac_digit_low <= 4'h9 && frac_digit_mid <= 4'h9 &&
    frac_digit_high <= 4'h9 && accum_low_register <= 4'h9 &&
    accum_mid_register <= 4'h9 |-> accum_top_register <= 4'h9)
    else $error("accumulator residue not decimal");

  c_ndc_high: cover property (ctl.valid && ctl.word.op == OP_CARRY && carry);
  c_halt: cover property (ctl.valid && ctl.word.op == OP_HALT);
  c_long_pulse: cover property ($fell(ctl.busy) && pw_digit == 4'h9);
  c_overrun: cover property (start && ctl.valid);

endmodule // fnpa_accumulator

// File: bench/fnpa_divider_model.sv
// Behavioural model of the divider and prescaler facing the accumulator
`timescale 1ns/1ps
module fnpa_divider_model #(
  parameter int PSC_HALF_NS = 125 // Half period of the prescaled clock
) (
  input wire logic ref_tick, // Bench request for a period end
  input wire logic divide_minus_one_select, // From the accumulator
  output logic acc_clock_pin, // Period-end pulse
  output logic prescaled_vco_clock, // VCO divided by ten
  output int short_periods // Periods divided by N minus one
);
  // ==========================================================
  // Prescaler
  // Runs free, as the real prescaler never stops
  initial begin
    prescaled_vco_clock = 1'b0;
    forever #(PSC_HALF_NS) prescaled_vco_clock = ~prescaled_vco_clock;
  end

  // ==========================================================
  // Period end
  // Odd offset keeps the pin unrelated in phase to the clock
  initial begin
    acc_clock_pin = 1'b0;
    short_periods = 0;
    forever begin
      @(posedge ref_tick);
      #37;
      // Terminal count drops by one for a period with select high
      if (divide_minus_one_select === 1'b1)
        short_periods = short_periods + 1;
      acc_clock_pin = 1'b1;
      #200;
      acc_clock_pin = 1'b0;
    end
  end
endmodule // fnpa_divider_model

// File: bench/tb_fractional_n_phase_accumulator.sv
// Self-checking bench of the BCD phase accumulator
`timescale 1ns/1ps
module tb_fractional_n_phase_accumulator;
  import fnpa_pkg::*;
  // ==========================================================
  // Signals
  localparam int PSC_NS = 250; // Prescaled clock period
  logic clk, srst, ce; // Clock, reset, enable
  logic [AV_ADDR_W-1:0] avs_address; // Bus address
  logic avs_read, avs_write, avs_waitrequest; // Bus control
  logic [31:0] avs_writedata, avs_readdata, rd; // Bus data
  logic acc_clock_pin, prescaled_vco_clock, ref_tick; // Far side
  logic divide_minus_one_select; // To the divider
  logic [2:0] corr_pulse_n, pulse_q; // Pulses and their last value
  int short_periods, errors, comparisons, seed, acc, frac, exp_short;
  int last_carry, nfall = 0, cyc = 0; // Model state and monitors
  int order [3]; // Which pulse fell in which place
  time fall_t [3], width [3]; // Pulse timing
  int corners [5] = '{207, 999, 0, 1, 500}; // Hand-picked fractions

  fnpa_accumulator DUT (.clk(clk), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_clock_pin(acc_clock_pin),
    .prescaled_vco_clock(prescaled_vco_clock),
    .divide_minus_one_select(divide_minus_one_select),
    .corr_pulse_n(corr_pulse_n));

  fnpa_divider_model #(.PSC_HALF_NS(PSC_NS / 2)) far (.ref_tick(ref_tick),
    .divide_minus_one_select(divide_minus_one_select),
    .acc_clock_pin(acc_clock_pin),
    .prescaled_vco_clock(prescaled_vco_clock),
    .short_periods(short_periods));

  // ==========================================================
  // Clock, cycle count and pulse monitor
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Records order and width of every correction pulse
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (pulse_q[i] === 1'b1 && corr_pulse_n[i] === 1'b0) begin
        fall_t[i] = $time;
        order[nfall % 3] = i;
        nfall = nfall + 1;
      end
      if (pulse_q[i] === 1'b0 && corr_pulse_n[i] === 1'b1)
        width[i] = $time - fall_t[i];
    end
    pulse_q <= corr_pulse_n;
  end

  // ==========================================================
  // Helpers
  function automatic logic [11:0] to_bcd(input int v);
    return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Load phase and synchroniser delay blur the width by up to one prescaled period
  task automatic chk_width(input time got, input int d);
    comparisons++;
    if (got + 50 < d * PSC_NS || got > (d + 1) * PSC_NS + 150) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, (d + 1) * PSC_NS);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [AV_ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
  endtask

  // One reference period, expectations from the BCD model
  task automatic period(input logic en);
    int t0, n, n0;
    t0 = cyc;
    n0 = nfall;
    exp_short = exp_short + last_carry;
    ref_tick <= 1'b1;
    repeat (8) @(posedge clk);
    ref_tick <= 1'b0;
    if (en) begin
      acc = acc + frac;
      last_carry = (acc >= 1000) ? 1 : 0;
      acc = acc % 1000;
    end
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end while ((rd[0] !== 1'b0 || rd[3] !== 1'b0) && n < 300);
    if (n >= 300) begin
      errors++;
      report_and_stop();
    end
    chk(rd, {16'h0, to_bcd(acc), 2'h0, 1'(last_carry), 1'b0});
    chk(32'(short_periods), 32'(exp_short));
    // Fill the rest of the period at the 100 kHz rate
    while (cyc - t0 < REF_PERIOD_CYC) @(posedge clk);
    chk(32'(nfall - n0), en ? 32'h3 : 32'h0);
    if (en) begin
      for (int i = 0; i < 3; i++)
        chk(32'(order[i]), 32'(2 - i));
      chk_width(width[2], acc % 10);
      chk_width(width[1], (acc / 10) % 10);
      chk_width(width[0], acc / 100);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 34;
    {errors, comparisons, acc, frac, exp_short, last_carry} = '0;
    srst = 1'b1;
    ce = 1'b1;
    {avs_read, avs_write, ref_tick} = 3'h0;
    avs_address = '0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // Reset values, then an unmapped place
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_EN_RST});
    bus(1'b0, REG_FRAC, 32'h0);
    chk(rd, {20'h0, FRAC_RST});
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    // Disabled: a period changes nothing
    frac = 207;
    bus(1'b1, REG_FRAC, {20'h0, to_bcd(frac)});
    period(1'b0);
    $display("test disabled done");
    bus(1'b1, REG_CTRL, 32'h1);
    for (int k = 0; k < 9; k++) begin
      frac = (k < 5) ? corners[k] : ($random(seed) & 32'h7fff_ffff) % 1000;
      bus(1'b1, REG_FRAC, {20'h0, to_bcd(frac)});
      bus(1'b0, REG_FRAC, 32'h0);
      chk(rd, {20'h0, to_bcd(frac)});
      repeat (4) period(1'b1);
      $display("test fraction %0d done", frac);
    end
    // Restart while running: sticky flag, cleared by writing one
    bus(1'b1, REG_FRAC, 32'h999);
    // Second period end lands well inside the shortest sequence
    ref_tick <= 1'b1;
    repeat (4) @(posedge clk);
    ref_tick <= 1'b0;
    repeat (4) @(posedge clk);
    ref_tick <= 1'b1;
    repeat (10) @(posedge clk);
    ref_tick <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[ST_OVR_BIT]), 32'h1);
    bus(1'b1, REG_STATUS, 32'h4);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[ST_OVR_BIT]), 32'h0);
    $display("test overrun done");
    report_and_stop();
  end
endmodule // tb_fractional_n_phase_accumulator
